//--- common/mdl_params.svh
// offsets, field positions, reset values and timing constants of the shared link memory block
`ifndef MDL_PARAMS_SVH
`define MDL_PARAMS_SVH
// avalon word addresses
`define MDL_A_STATION 8'h00
`define MDL_A_COUNT 8'h01
`define MDL_A_PATTERN 8'h02
`define MDL_A_RETRY 8'h03
`define MDL_A_WATCH 8'h04
`define MDL_A_STATUS 8'h05
`define MDL_A_ALT 8'h06
`define MDL_A_CTRL 8'h07
`define MDL_MEM_DEPTH 7'h70
// reset values
`define MDL_RST_STATION 16'h0000
`define MDL_RST_COUNT 16'h0007
`define MDL_RST_PATTERN 16'h0000
`define MDL_RST_RETRY 16'h0003
`define MDL_RST_WATCH 16'h0005
// ranges
`define MDL_MAX_STATION 16'h0007
`define MDL_MAX_PATTERN 16'h0002
`define MDL_MAX_RETRY 16'h000A
`define MDL_MIN_WATCH 16'h0005
`define MDL_MAX_WATCH 16'h00FF
// link area layout: word area 10 per station, bit area 64 bits = 4 words per station
`define MDL_WORD_STRIDE 7'h0A
`define MDL_BIT_BASE 7'h50
`define MDL_BIT_STRIDE 7'h04
`define MDL_NW_NARROW 4'h4
`define MDL_NW_WIDE 4'h8
`define MDL_LEN_P0 4'h4
`define MDL_LEN_P1 4'h6
`define MDL_LEN_P2 4'hC
`define MDL_PAT_WIDE 2'h2
`define MDL_PAT_P1 2'h1
// timing
`define MDL_TICK_MS 10
`define MDL_CLK_MHZ 50
`endif

//--- common/mdl_pkg.sv
// types shared by the shared link memory block
package mdl_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_POLL = 2'b10,
      ST_WAIT = 2'b11
   } mdl_state_t;
   typedef struct packed {
      logic valid;
      logic poll;
      logic err;
      logic [2:0] station;
      logic [1:0] pattern;
      logic [3:0] index;
      logic last;
      logic [15:0] data;
   } mdl_frame_t;
   typedef struct packed {
      logic running;
      logic master_err;
      logic [6:0] slave_err;
   } mdl_flags_t;
endpackage : mdl_pkg

//--- logic/mdl_link.sv
// multidrop shared link memory controller with avalon register slave
`include "mdl_params.svh"
// How it works
// - station number 0 makes a master, 1..7 a slave; resets to 0
// - master polls slave count stations (1..7, default 7); slaves ignore it
// - master's pattern 0..2 sets bit and word points per station
// - unanswered poll retried up to retry limit, then station flagged in error
// - watch timeout is count of 10 ms units, 5..255, default 5
// - channel select low runs link on first channel, high on second
// - master sequence error flag raised on master transfer error
// - seven slave error flags, indexed by station 1..7
// - running flag held while the link operates
// - pattern 0: four words per station from word 10n
// - pattern 1: 32 bits from bit 64n plus four words
// - pattern 2: 64 bits from bit 64n and eight words from 10n
// - alternate flags: running, master error, then slave n at n+1
// - link error freezes link area at last good contents
// - link area updated from link traffic whenever the link is running
module mdl_link #(
   parameter int unsigned TICK_CYC = `MDL_TICK_MS * 1000 * `MDL_CLK_MHZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic param_present_flag,
   input wire logic channel_select_bit,
   output logic channel_sel,
   input wire mdl_pkg::mdl_frame_t lnk_rx,
   output mdl_pkg::mdl_frame_t lnk_tx,
   output mdl_pkg::mdl_flags_t flags,
   output logic [8:0] alt_flags
);
   import mdl_pkg::*;

   // link area address of item k of a station's frame
   function automatic logic [6:0] area_addr(input logic [2:0] st, input logic [1:0] pat,
                                            input logic [3:0] k);
      logic [3:0] nw;
      nw = (pat == `MDL_PAT_WIDE) ? `MDL_NW_WIDE : `MDL_NW_NARROW;
      if (k < nw) begin
         area_addr = 7'(7'(st) * `MDL_WORD_STRIDE + 7'(k));
      end else begin
         area_addr = 7'(`MDL_BIT_BASE + 7'(st) * `MDL_BIT_STRIDE + 7'(k - nw));
      end
   endfunction : area_addr

   // frame length in 16-bit items for a pattern
   function automatic logic [3:0] frame_len(input logic [1:0] pat);
      case (pat)
         `MDL_PAT_WIDE: frame_len = `MDL_LEN_P2;
         `MDL_PAT_P1: frame_len = `MDL_LEN_P1;
         default: frame_len = `MDL_LEN_P0;
      endcase
   endfunction : frame_len

   logic [15:0] station_r, count_r, pattern_r, retry_r, watch_r;
   logic [15:0] mem_r [0:`MDL_MEM_DEPTH-1];
   logic [31:0] readdata_r, tmr_r;
   logic [7:0] ticks_r, err_r, err_nxt, err_set, err_clr;
   logic ack_r, run_r, ch_r;
   logic [2:0] s_r, s_nxt;
   logic [3:0] k_r, k_nxt, try_r, try_nxt;
   logic [1:0] pat_lk_r, pat_lk_nxt;
   mdl_state_t st_r, st_nxt;
   mdl_frame_t tx_r, tx_nxt;

   // effective settings, out-of-range values clamped, except pattern above 2 read as 0 and count 0 read as 7, so the machine stays sane
   wire [2:0] me = (station_r > `MDL_MAX_STATION) ? 3'h7 : station_r[2:0];
   wire is_master = (me == 3'h0);
   wire [2:0] cnt_eff = (count_r == 16'h0 || count_r > `MDL_MAX_STATION) ? 3'h7 :
                        count_r[2:0];
   wire [1:0] pat_eff = (pattern_r > `MDL_MAX_PATTERN) ? 2'h0 : pattern_r[1:0];
   wire [3:0] retry_eff = (retry_r > `MDL_MAX_RETRY) ? 4'hA : retry_r[3:0];
   wire [7:0] watch_eff = (watch_r < `MDL_MIN_WATCH) ? 8'h05 :
                          (watch_r > `MDL_MAX_WATCH) ? 8'hFF : watch_r[7:0];
   // pattern is latched at frame start so a mid-frame write cannot change its length
   wire [1:0] pat_use = pat_lk_r;
   wire [3:0] len = frame_len(pat_use);
   wire timeout = (ticks_r >= watch_eff);

   // link receive decode; errored words never reach the area, so it freezes
   wire hear = lnk_rx.valid && !lnk_rx.err && run_r;
   wire rx_ok = hear && !lnk_rx.poll;
   wire [6:0] rx_addr = area_addr(lnk_rx.station, lnk_rx.pattern, lnk_rx.index);
   wire from_peer = is_master ? (lnk_rx.station == s_r) : (lnk_rx.station == 3'h0);
   wire fail = (st_r == ST_WAIT) && (timeout || (lnk_rx.valid && lnk_rx.err &&
               lnk_rx.station == s_r));
   wire done_peer = (st_r == ST_WAIT) && rx_ok && from_peer && lnk_rx.last;

   // bus decode; a bus write to the area waits while link traffic owns the port
   wire req = read || write;
   wire mem_sel = address[7] && (address[6:0] < `MDL_MEM_DEPTH);
   wire mem_clash = write && mem_sel && rx_ok;
   wire bus_done = req && ack_r && !mem_clash;
   wire bus_wr = write && bus_done;
   wire [6:0] mem_idx = address[6:0];
   wire [8:0] status_v = {run_r, err_r[7:1], err_r[0]};
   wire [8:0] alt_v = {err_r[7:1], err_r[0], run_r};
   wire [31:0] rd_mux =
      mem_sel ? {16'h0, mem_r[mem_idx]} :
      (address == `MDL_A_STATION) ? {16'h0, station_r} :
      (address == `MDL_A_COUNT) ? {16'h0, count_r} :
      (address == `MDL_A_PATTERN) ? {16'h0, pattern_r} :
      (address == `MDL_A_RETRY) ? {16'h0, retry_r} :
      (address == `MDL_A_WATCH) ? {16'h0, watch_r} :
      (address == `MDL_A_STATUS) ? {23'h0, status_v} :
      (address == `MDL_A_ALT) ? {23'h0, alt_v} :
      (address == `MDL_A_CTRL) ? {30'h0, param_present_flag, channel_select_bit} : 32'h0;

   assign waitrequest = req && !bus_done;
   assign readdata = readdata_r;
   assign lnk_tx = tx_r;
   assign channel_sel = ch_r;
   assign flags = '{running: run_r, master_err: err_r[0], slave_err: err_r[7:1]};
   assign alt_flags = alt_v;

   // bus handshake: one wait cycle, read data registered ahead of completion
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
         readdata_r <= 32'h0;
      end else begin
         ack_r <= waitrequest;
         readdata_r <= read ? rd_mux : readdata_r;
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         station_r <= `MDL_RST_STATION;
         count_r <= `MDL_RST_COUNT;
         pattern_r <= `MDL_RST_PATTERN;
         retry_r <= `MDL_RST_RETRY;
         watch_r <= `MDL_RST_WATCH;
      end else if (bus_wr) begin
         if (address == `MDL_A_STATION) station_r <= writedata[15:0];
         if (address == `MDL_A_COUNT) count_r <= writedata[15:0];
         if (address == `MDL_A_PATTERN) pattern_r <= writedata[15:0];
         if (address == `MDL_A_RETRY) retry_r <= writedata[15:0];
         if (address == `MDL_A_WATCH) watch_r <= writedata[15:0];
      end
   end

   // link area: link traffic wins the port whenever it arrives
   always_ff @(posedge clk) begin
      if (rx_ok) begin
         mem_r[rx_addr] <= lnk_rx.data;
      end else if (bus_wr && mem_sel) begin
         mem_r[mem_idx] <= writedata[15:0];
      end
   end

   // watch timer in 10 ms ticks, restarted on state change or peer traffic
   wire tmr_clr = (st_r != st_nxt) || !run_r || (hear && from_peer);
   always_ff @(posedge clk) begin
      if (sys_rst || tmr_clr) begin
         tmr_r <= 32'h0;
         ticks_r <= 8'h0;
      end else if (tmr_r == TICK_CYC - 1) begin
         tmr_r <= 32'h0;
         ticks_r <= (ticks_r == 8'hFF) ? ticks_r : ticks_r + 8'h1;
      end else begin
         tmr_r <= tmr_r + 32'h1;
      end
   end

   // refresh sequencer: master sends, then polls 1..count; slave answers its poll
   always_comb begin
      st_nxt = st_r;
      s_nxt = s_r;
      k_nxt = k_r;
      try_nxt = try_r;
      pat_lk_nxt = pat_lk_r;
      case (st_r)
         ST_IDLE: begin
            k_nxt = 4'h0;
            if (is_master) begin
               st_nxt = ST_SEND;
               pat_lk_nxt = pat_eff;
            end else if (hear && lnk_rx.poll && lnk_rx.station == me) begin
               st_nxt = ST_SEND;
               pat_lk_nxt = lnk_rx.pattern;
            end
         end
         ST_SEND: begin
            k_nxt = k_r + 4'h1;
            if (k_r == len - 4'h1) begin
               st_nxt = is_master ? ST_POLL : ST_IDLE;
               s_nxt = 3'h1;
               try_nxt = 4'h0;
            end
         end
         ST_POLL: st_nxt = ST_WAIT;
         ST_WAIT: begin
            if (fail && try_r < retry_eff) begin
               st_nxt = ST_POLL;
               try_nxt = try_r + 4'h1;
            end else if (fail || done_peer) begin
               try_nxt = 4'h0;
               k_nxt = 4'h0;
               st_nxt = (s_r == cnt_eff) ? ST_SEND : ST_POLL;
               s_nxt = (s_r == cnt_eff) ? s_r : s_r + 3'h1;
               pat_lk_nxt = (s_r == cnt_eff) ? pat_eff : pat_lk_r;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      if (!run_r) begin
         st_nxt = ST_IDLE;
      end
   end

   // transmit word, one item per cycle while sending, a token while polling
   always_comb begin
      tx_nxt = '0;
      if (st_r == ST_SEND) begin
         tx_nxt.valid = 1'b1;
         tx_nxt.station = me;
         tx_nxt.pattern = pat_use;
         tx_nxt.index = k_r;
         tx_nxt.data = mem_r[area_addr(me, pat_use, k_r)];
         tx_nxt.last = (k_r == len - 4'h1);
      end else if (st_r == ST_POLL) begin
         tx_nxt.valid = 1'b1;
         tx_nxt.poll = 1'b1;
         tx_nxt.station = s_r;
         tx_nxt.pattern = pat_eff;
      end
   end

   // error flags: set wins over clear in the same cycle
   always_comb begin
      err_set = 8'h0;
      err_clr = 8'h0;
      if (lnk_rx.valid && lnk_rx.err && run_r) err_set[lnk_rx.station] = 1'b1;
      if (fail && try_r >= retry_eff) err_set[s_r] = 1'b1;
      if (!is_master && run_r && st_r == ST_IDLE && timeout) err_set[0] = 1'b1;
      if (done_peer) err_clr[s_r] = 1'b1;
      if (!is_master && rx_ok && lnk_rx.station == 3'h0 && lnk_rx.last) err_clr[0] = 1'b1;
      err_nxt = (err_r & ~err_clr) | err_set;
   end

   // sequencer and status state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         s_r <= 3'h1;
         k_r <= 4'h0;
         try_r <= 4'h0;
         pat_lk_r <= 2'h0;
         tx_r <= '0;
         err_r <= 8'h0;
         run_r <= 1'b0;
         ch_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         s_r <= s_nxt;
         k_r <= k_nxt;
         try_r <= try_nxt;
         pat_lk_r <= pat_lk_nxt;
         tx_r <= tx_nxt;
         err_r <= err_nxt;
         run_r <= param_present_flag;
         ch_r <= channel_select_bit;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   poll_only_master_a: assert property (tx_r.poll |-> station_r == 16'h0)
      else $error("poll token sent by a slave");
   poll_in_range_a: assert property (tx_r.poll |-> tx_r.station >= 3'h1 &&
      tx_r.station <= cnt_eff)
      else $error("polled station outside slave count");
   frame_length_a: assert property (tx_r.valid && !tx_r.poll && tx_r.last |->
      tx_r.index == frame_len(tx_r.pattern) - 4'h1)
      else $error("frame length does not match pattern");
   retry_poll_a: assert property (st_r == ST_WAIT && fail && try_r < retry_eff && run_r |=>
      st_r == ST_POLL ##1 tx_r.poll && tx_r.station == $past(s_r, 2))
      else $error("retry did not repoll the same station");
   retry_error_a: assert property (st_r == ST_WAIT && fail && try_r >= retry_eff |=>
      err_r[$past(s_r)])
      else $error("exhausted retries not flagged");
   chan_follow_a: assert property (channel_select_bit |=> channel_sel)
      else $error("channel select not followed");
   run_follow_a: assert property (param_present_flag ##1 param_present_flag |->
      flags.running)
      else $error("running flag low while configured");
   alt_map_a: assert property (alt_flags[0] == flags.running &&
      alt_flags[1] == flags.master_err && alt_flags[8:2] == flags.slave_err)
      else $error("alternate flags disagree");
   freeze_a: assert property (lnk_rx.valid && lnk_rx.err && !bus_wr |=>
      mem_r[$past(rx_addr)] == $past(mem_r[rx_addr]))
      else $error("errored word changed link area");
   rx_update_a: assert property (rx_ok |=> mem_r[$past(rx_addr)] == $past(lnk_rx.data))
      else $error("link word not stored");
   bus_answer_a: assert property (req && !ack_r && !(write && mem_sel) |=> !waitrequest)
      else $error("bus answer late");
endmodule : mdl_link

//--- tb/mdl_peer.sv
// behavioural model of the other stations sharing the link
`include "mdl_params.svh"
module mdl_peer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire mdl_pkg::mdl_frame_t lnk_tx,
   input wire logic [6:0] mute,
   input wire logic [7:0] tag,
   input wire logic bad0,
   output mdl_pkg::mdl_frame_t lnk_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   import mdl_pkg::*;
   logic [3:0] left_r;
   logic [3:0] idx_r;
   logic [2:0] stn_r;
   logic [1:0] pat_r;
   wire tok = lnk_tx.valid && lnk_tx.poll;
   // frame length follows the pattern carried by the poll token
   wire [3:0] len = (lnk_tx.pattern == 2'h2) ? `MDL_LEN_P2 :
      (lnk_tx.pattern == 2'h1) ? `MDL_LEN_P1 : `MDL_LEN_P0;
   // answer at once; the idle line toggles so a stale word is never mistaken for data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lnk_rx <= '0;
         left_r <= 4'h0;
      end else if (left_r != 4'h0) begin
         lnk_rx <= '{1'b1, 1'b0, 1'b0, stn_r, pat_r, idx_r, left_r == 4'h1,
            {tag, 1'b0, stn_r, idx_r}};
         idx_r <= idx_r + 4'h1;
         left_r <= left_r - 4'h1;
      end else begin
         lnk_rx.valid <= 1'b0;
         lnk_rx.data <= ~lnk_rx.data;
         if (tok && bad0 && lnk_tx.station == 3'h1) begin
            lnk_rx <= '{1'b1, 1'b0, 1'b1, 3'h0, 2'h0, 4'h0, 1'b1, 16'h0};
         end else if (tok && !mute[lnk_tx.station - 3'h1]) begin
            left_r <= len;
            idx_r <= 4'h0;
            stn_r <= lnk_tx.station;
            pat_r <= lnk_tx.pattern;
         end
      end
   end
endmodule : mdl_peer

//--- tb/testbench.sv
// self-checking bench for the shared link memory controller
`include "mdl_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mdl_pkg::*;
   logic clk, sys_rst = 1'b1, read = 1'b0, write = 1'b0, bad0 = 1'b0;
   logic param_present_flag = 1'b0, channel_select_bit = 1'b0;
   logic [7:0] address = 8'h00, tag = 8'h3C, cnt1 = 8'h00, cnt2 = 8'h00, mark;
   logic [31:0] writedata = 32'h0, readdata;
   logic waitrequest, channel_sel;
   logic [6:0] mute = 7'h00;
   logic [8:0] alt_flags;
   logic [2:0] last_poll = 3'h0;
   logic [31:0] rst_tab [5] = '{32'h0, 32'h7, 32'h0, 32'h3, 32'h5};
   mdl_frame_t lnk_rx, lnk_tx;
   mdl_flags_t flags;
   int n_fail = 0, cmp_count = 0;
   mdl_link #(.TICK_CYC(20)) mdl_link_inst (.clk(clk), .sys_rst(sys_rst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .param_present_flag(param_present_flag), .channel_select_bit(channel_select_bit),
      .channel_sel(channel_sel), .lnk_rx(lnk_rx), .lnk_tx(lnk_tx), .flags(flags),
      .alt_flags(alt_flags));
   mdl_peer mdl_peer_inst (.clk(clk), .sys_rst(sys_rst), .lnk_tx(lnk_tx), .mute(mute),
      .tag(tag), .bad0(bad0), .lnk_rx(lnk_rx));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] pw(logic [7:0] t, logic [2:0] s, logic [3:0] i);
      return {16'h0, t, 1'b0, s, i};
   endfunction : pw
   task automatic give_verdict();
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask : chk
   // one avalon transfer: hold everything until waitrequest is seen low at an edge
   task automatic av(input logic [7:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r);
      int k;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 200);
      r = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (k >= 200) begin
         n_fail++;
         give_verdict();
      end
   endtask : av
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      av(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      av(a, 1'b1, d, r);
   endtask : wr
   // bounded wait on link progress; running out ends the run as a failure
   task automatic wait_on(input int what);
      for (int k = 0; k < 3000; k++) begin
         @(posedge clk);
         if ((what == 0 && cnt2 >= 8'h2) || (what == 1 && flags.slave_err[1] === 1'b1) ||
            (what == 2 && flags.master_err === 1'b1) || (what == 3 && cnt1 >= mark)) return;
      end
      n_fail++;
      give_verdict();
   endtask : wait_on
   // poll order watch and count of whole frames per peer
   always @(posedge clk) begin
      if (lnk_tx.valid === 1'b1 && lnk_tx.poll === 1'b1 && lnk_tx.station !== last_poll) begin
         chk(32'(lnk_tx.station), (last_poll == 3'h2) ? 32'h1 : 32'(last_poll + 3'h1));
         last_poll <= lnk_tx.station;
      end
      if (lnk_tx.valid === 1'b1 && lnk_tx.poll === 1'b0 && lnk_tx.index == 4'h0) begin
         chk(32'({lnk_tx.station, lnk_tx.data}), 32'h1234);
      end
      if (lnk_rx.valid && lnk_rx.last && !lnk_rx.err && lnk_rx.station == 3'h1)
         cnt1 <= cnt1 + 8'h1;
      if (lnk_rx.valid && lnk_rx.last && !lnk_rx.err && lnk_rx.station == 3'h2)
         cnt2 <= cnt2 + 8'h1;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd(8'(i), rst_tab[i]);
      rd(8'h08, 32'h0);
      wr(8'h05, 32'h1FF);
      rd(8'h05, 32'h0);
      wr(8'h01, 32'h2);
      wr(8'h02, 32'h2);
      rd(8'h02, 32'h2);
      wr(8'h80, 32'h1234);
      rd(8'h80, 32'h1234);
      param_present_flag <= 1'b1;
      wait_on(0);
      rd(8'h8A, pw(8'h3C, 3'h1, 4'h0));
      rd(8'h9B, pw(8'h3C, 3'h2, 4'h7));
      rd(8'hDB, pw(8'h3C, 3'h2, 4'hB));
      rd(8'h05, 32'h100);
      chk(32'(alt_flags), 32'h1);
      channel_select_bit <= 1'b1;
      rd(8'h07, 32'h3);
      chk(32'(channel_sel), 32'h1);
      tag <= 8'h5A;
      mute <= 7'h02;
      wait_on(1);
      chk({25'h0, flags.slave_err}, 32'h2);
      chk(32'(alt_flags), 32'h9);
      mark = cnt1 + 8'h2;
      wait_on(3);
      rd(8'h8A, pw(8'h5A, 3'h1, 4'h0));
      rd(8'h94, pw(8'h3C, 3'h2, 4'h0));
      rd(8'h05, 32'h104);
      wr(8'h02, 32'h1);
      mark = cnt1 + 8'h2;
      wait_on(3);
      rd(8'hD5, pw(8'h5A, 3'h1, 4'h5));
      wr(8'h02, 32'h0);
      tag <= 8'h77;
      mark = cnt1 + 8'h2;
      wait_on(3);
      rd(8'h8D, pw(8'h77, 3'h1, 4'h3));
      mute <= 7'h00;
      bad0 <= 1'b1;
      wait_on(2);
      chk({31'h0, alt_flags[1]}, 32'h1);
      give_verdict();
   end
endmodule : testbench
